/* File: rtl/packer_consts.svh */
// constants of the cyclic input packer: offsets, fields, resets and timing
// assumes inclusion by every file of the packer that needs a number
`ifndef PACKER_CONSTS_SVH
`define PACKER_CONSTS_SVH
// ****************************************
// layouts and connection answers
// ****************************************
`define PK_LAYOUT_POS      8'h01
`define PK_LAYOUT_VEL      8'h03
`define PK_LAYOUT_SYNC     8'h68
`define PK_LAYOUT_CFG      8'h67
`define PK_WORDS_POS       3'h1
`define PK_WORDS_VEL       3'h2
`define PK_WORDS_SYNC      3'h5
`define PK_ERR_NONE        16'h0000
`define PK_ERR_SEGMENT     16'h0315
// ****************************************
// packet fields
// ****************************************
`define PK_POS_MAX         32'h3FFFFFFF
`define PK_CNT_MAX         15'h7FFF
`define PK_CNT_MSB         14
`define PK_SYNC_BIT        16
`define PK_VEL_PER_S       32'h000003E8
`define PK_VEL_PER_MIN     32'h0000EA60
`define PK_SPAN_SHIFT      16
// ****************************************
// register map and reset values
// ****************************************
`define PK_REG_CTRL        8'h00
`define PK_REG_SPAN        8'h04
`define PK_REG_STATUS      8'h08
`define PK_REG_IRQ_STAT    8'h0C
`define PK_REG_IRQ_CLR     8'h10
`define PK_REG_IRQ_EN      8'h14
`define PK_CTRL_FMT_LSB    0
`define PK_CTRL_SCALE_BIT  2
`define PK_SPAN_RESET      32'h00010000
`define PK_IRQ_REFRESH     0
`define PK_IRQ_REJECT      1
`define PK_IRQ_PACKET      2
`define PK_AXI_OKAY        2'h0
`define PK_AXI_SLVERR      2'h2
// ****************************************
// timing
// ****************************************
`define PK_CLK_NS          10
`define PK_REFRESH_NS      1000000
`define PK_MS_CYCLES       (`PK_REFRESH_NS / `PK_CLK_NS)
`endif

/* File: rtl/packer_pkg.sv */
// types shared by the cyclic input packer
// assumes packer_consts.svh holds the numbers
package packer_pkg;
  typedef enum {ST_IDLE, ST_LOAD, ST_FETCH, ST_WAIT} txState_type;
  typedef enum logic [1:0] {FMT_PER_MS, FMT_PER_S, FMT_PER_MIN} velFormat_type;
endpackage : packer_pkg

/* File: rtl/pin_sync.sv */
// three-stage synchroniser for a level arriving from a pin
// assumes the pin is slow compared with clk
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pinIn,
  output logic      levelOut
);
  logic stage1_q;
  logic stage2_q;
  logic stage3_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // a change counts only once the second and third stage agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      levelOut <= 1'b0;
    end else if (stage2_q == stage3_q) begin
      levelOut <= stage3_q;
    end
  end
endmodule : pin_sync

/* File: rtl/word_memory.sv */
// five-word packet image, written as a whole, read one word at a time
// assumes the writer never writes while a word is being read out
`timescale 1ns/1ps
module word_memory (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         wrEn,
  input  wire logic [159:0] wrWords,
  input  wire logic [2:0]   rdAddr,
  output logic      [31:0]  rdData
);
  logic [31:0] mem_q [5];

  generate
    for (genvar i = 0; i < 5; i++) begin : g_word
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          mem_q[i] <= 32'h00000000;
        end else if (wrEn) begin
          mem_q[i] <= wrWords[32*i +: 32];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= 32'h00000000;
    end else begin
      rdData <= (rdAddr < 3'h5) ? mem_q[rdAddr] : 32'h00000000;
    end
  end
endmodule : word_memory

/* File: rtl/encoder_input_assembly_packer.sv */
// cyclic input packer of a networked encoder with an AXI4-Lite register slave
// assumes position and timer come from same-clock logic, the sync lock from a pin
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "packer_consts.svh"

module encoder_input_assembly_packer
  import packer_pkg::*;
#(
  parameter int MS_CYCLES = `PK_MS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [31:0] posIn,
  input  wire logic [63:0] timerIn,
  input  wire logic        syncLockPin,
  input  wire logic        connReqValid,
  input  wire logic [7:0]  connReqLayout,
  input  wire logic [7:0]  connReqCfgLayout,
  input  wire logic [15:0] connReqRpiMs,
  input  wire logic        connClose,
  output logic             connRespValid,
  output logic [15:0]      connRespCode,
  output logic             connActive,
  output logic             pktValid,
  output logic [31:0]      pktData,
  output logic [2:0]       pktIndex,
  output logic             pktLast,
  input  wire logic        pktReady,
  output logic             irq,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  // ****************************************
  // declarations
  // ****************************************
  logic [31:0]   msCnt_q;
  logic          msTick_q;
  logic          timeSyncFlag;
  logic [31:0]   snapPos_q;
  logic [31:0]   snapVel_q;
  logic [63:0]   snapTime_q;
  logic [14:0]   updCount_q;
  logic          snapSync_q;
  logic [31:0]   prevScaled_q;
  logic [31:0]   posClamped;
  logic [63:0]   posProduct;
  logic [31:0]   posForVel;
  logic [31:0]   posDelta;
  logic [63:0]   velProduct;
  logic [31:0]   velOut;
  logic [1:0]    velFormat_q;
  logic          scaleEver_q;
  logic [31:0]   span_q;
  logic [7:0]    layout_q;
  logic [2:0]    wordCount_q;
  logic [15:0]   rpi_q;
  logic [15:0]   rpiCnt_q;
  logic          sendStart;
  logic          layoutOk;
  txState_type   txState_q;
  logic [2:0]    idx_q;
  logic [31:0]   memData;
  logic [159:0]  image;
  logic [2:0]    irqStat_q;
  logic [2:0]    irqEn_q;
  logic [2:0]    irqEvent;
  logic [2:0]    irqClr;
  logic          awGot_q;
  logic          wGot_q;
  logic [7:0]    awAddr_q;
  logic [31:0]   wData_q;
  logic [3:0]    wStrb_q;
  logic          doWrite;
  logic          wrMapped;
  logic [14:0]   pktCount_q;
  logic          pktSync_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ****************************************
  // refresh tick and time sync
  // ****************************************
  // refresh runs from its own divider so the controller's read rate has no say
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msCnt_q  <= 32'h00000000;
      msTick_q <= 1'b0;
    end else if (msCnt_q == 32'(MS_CYCLES - 1)) begin
      msCnt_q  <= 32'h00000000;
      msTick_q <= 1'b1;
    end else begin
      msCnt_q  <= msCnt_q + 32'h00000001;
      msTick_q <= 1'b0;
    end
  end

  pin_sync u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .pinIn    (syncLockPin),
    .levelOut (timeSyncFlag)
  );

  // ****************************************
  // position, velocity and snapshot
  // ****************************************
  assign posClamped = (posIn > `PK_POS_MAX) ? `PK_POS_MAX : posIn;
  assign posProduct = {32'h00000000, posClamped} * {32'h00000000, span_q};
  // once scaling was switched on the velocity is taken from the scaled position for good; the position word stays unscaled
  assign posForVel  = scaleEver_q ? posProduct[`PK_SPAN_SHIFT +: 32] : posClamped;
  assign posDelta   = posForVel - prevScaled_q;

  always_comb begin
    velProduct = {{32{posDelta[31]}}, posDelta};
    case (velFormat_q)
      2'h1:    velProduct = {{32{posDelta[31]}}, posDelta} * {32'h00000000, `PK_VEL_PER_S};
      2'h2:    velProduct = {{32{posDelta[31]}}, posDelta} * {32'h00000000, `PK_VEL_PER_MIN};
      default: velProduct = {{32{posDelta[31]}}, posDelta};
    endcase
    velOut = velProduct[31:0];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      snapPos_q    <= 32'h00000000;
      snapVel_q    <= 32'h00000000;
      snapTime_q   <= 64'h0000000000000000;
      snapSync_q   <= 1'b0;
      prevScaled_q <= 32'h00000000;
    end else if (msTick_q) begin
      snapPos_q    <= posClamped;
      snapVel_q    <= velOut;
      snapTime_q   <= timerIn;
      snapSync_q   <= timeSyncFlag;
      prevScaled_q <= posForVel;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      updCount_q <= 15'h0000;
    end else if (msTick_q) begin
      updCount_q <= (updCount_q == `PK_CNT_MAX) ? 15'h0000 : updCount_q + 15'h0001;
    end
  end

  a_count_step: assert property (msTick_q |=> updCount_q == 15'($past(updCount_q) + 15'h0001))
    else $error("update counter did not step by one");
  a_count_hold: assert property (!msTick_q |=> $stable(updCount_q))
    else $error("update counter moved without a refresh");
  a_time_latch: assert property (msTick_q |=> snapTime_q == $past(timerIn))
    else $error("timestamp not latched with position");
  a_pos_bound: assert property (snapPos_q <= `PK_POS_MAX)
    else $error("position above its maximum");

  // ****************************************
  // connection handling
  // ****************************************
  assign layoutOk = (connReqLayout == `PK_LAYOUT_POS) || (connReqLayout == `PK_LAYOUT_VEL)
                 || (connReqLayout == `PK_LAYOUT_SYNC);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      connRespValid <= 1'b0;
      connRespCode  <= `PK_ERR_NONE;
      connActive    <= 1'b0;
      layout_q      <= `PK_LAYOUT_POS;
      wordCount_q   <= `PK_WORDS_POS;
      rpi_q         <= 16'h0001;
    end else begin
      connRespValid <= connReqValid;
      if (connReqValid && (!layoutOk || connReqCfgLayout != `PK_LAYOUT_CFG)) begin
        connRespCode <= `PK_ERR_SEGMENT;
      end else if (connReqValid) begin
        connRespCode <= `PK_ERR_NONE;
        connActive   <= 1'b1;
        layout_q     <= connReqLayout;
        // a zero interval would stall the packet timer, so it is taken as one
        rpi_q        <= (connReqRpiMs == 16'h0000) ? 16'h0001 : connReqRpiMs;
        case (connReqLayout)
          `PK_LAYOUT_VEL:  wordCount_q <= `PK_WORDS_VEL;
          `PK_LAYOUT_SYNC: wordCount_q <= `PK_WORDS_SYNC;
          default:         wordCount_q <= `PK_WORDS_POS;
        endcase
      end else if (connClose) begin
        connActive <= 1'b0;
      end
    end
  end

  a_reject_code: assert property (connReqValid && !layoutOk |=> connRespValid
                                  && connRespCode == `PK_ERR_SEGMENT)
    else $error("unsupported layout not refused");
  a_cfg_reject: assert property (connReqValid && connReqCfgLayout != `PK_LAYOUT_CFG
                                 |=> connRespCode == `PK_ERR_SEGMENT)
    else $error("wrong configuration layout not refused");

  // ****************************************
  // packet interval and transmit
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rpiCnt_q <= 16'h0000;
    end else if (!connActive) begin
      rpiCnt_q <= 16'h0000;
    end else if (msTick_q) begin
      rpiCnt_q <= (rpiCnt_q >= rpi_q - 16'h0001) ? 16'h0000 : rpiCnt_q + 16'h0001;
    end
  end

  // an interval that ends while a packet is still out is skipped, not queued
  assign sendStart = connActive && msTick_q && (rpiCnt_q >= rpi_q - 16'h0001)
                  && (txState_q == ST_IDLE);

  // word order is the same for every layout; only the velocity word is zeroed, in the position layout
  assign image = {{15'h0000, snapSync_q, 1'b0, updCount_q},
                  snapTime_q[63:32], snapTime_q[31:0],
                  (layout_q == `PK_LAYOUT_POS) ? 32'h00000000 : snapVel_q,
                  snapPos_q};

  word_memory u_mem (
    .clk     (clk),
    .rst_b   (rst_b),
    .wrEn    (sendStart),
    .wrWords (image),
    .rdAddr  (idx_q),
    .rdData  (memData)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txState_q <= ST_IDLE;
      idx_q     <= 3'h0;
      pktValid  <= 1'b0;
      pktData   <= 32'h00000000;
      pktIndex  <= 3'h0;
      pktLast   <= 1'b0;
    end else begin
      case (txState_q)
        ST_IDLE: begin
          idx_q <= 3'h0;
          if (sendStart) begin
            txState_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          txState_q <= ST_FETCH;
        end
        ST_FETCH: begin
          pktValid  <= 1'b1;
          pktData   <= memData;
          pktIndex  <= idx_q;
          pktLast   <= (idx_q == wordCount_q - 3'h1);
          txState_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (pktReady) begin
            pktValid <= 1'b0;
            pktLast  <= 1'b0;
            if (pktLast) begin
              txState_q <= ST_IDLE;
            end else begin
              idx_q     <= idx_q + 3'h1;
              txState_q <= ST_LOAD;
            end
          end
        end
        default: begin
          txState_q <= ST_IDLE;
        end
      endcase
    end
  end

  a_word_count: assert property (pktValid && pktLast |-> pktIndex == wordCount_q - 3'h1)
    else $error("packet length does not match layout");
  // the live counter moves on while a packet is out, so word 4 is held against its frozen copy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pktCount_q <= 15'h0000;
      pktSync_q  <= 1'b0;
    end else if (sendStart) begin
      pktCount_q <= updCount_q;
      pktSync_q  <= snapSync_q;
    end
  end

  a_sync_word: assert property (pktValid && pktIndex == 3'h4
                                |-> pktData == {15'h0000, pktSync_q, 1'b0, pktCount_q})
    else $error("word 4 counter or flag wrong");
  a_pkt_hold: assert property (pktValid && !pktReady |=> pktValid && $stable(pktData))
    else $error("packet word dropped before accepted");

  // ****************************************
  // interrupts
  // ****************************************
  assign irqEvent = {(txState_q == ST_WAIT) && pktReady && pktLast,
                     connReqValid && !layoutOk, msTick_q};
  assign irqClr   = (doWrite && awAddr_q == `PK_REG_IRQ_CLR) ? wData_q[2:0] : 3'h0;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStat_q <= 3'h0;
      irq       <= 1'b0;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClr) | irqEvent;
      irq       <= |(((irqStat_q & ~irqClr) | irqEvent) & irqEn_q);
    end
  end

  a_irq_level: assert property ($stable(irqEn_q) |-> irq == |(irqStat_q & irqEn_q))
    else $error("interrupt output disagrees with status");

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign doWrite  = awGot_q && wGot_q && !bvalid;
  assign wrMapped = (awAddr_q == `PK_REG_CTRL) || (awAddr_q == `PK_REG_SPAN)
                 || (awAddr_q == `PK_REG_IRQ_CLR) || (awAddr_q == `PK_REG_IRQ_EN);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awGot_q  <= 1'b0;
      wGot_q   <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= `PK_AXI_OKAY;
    end else begin
      awready <= !awGot_q && !(awvalid && awready) && !bvalid;
      wready  <= !wGot_q && !(wvalid && wready) && !bvalid;
      if (awvalid && awready) begin
        awGot_q  <= 1'b1;
        awAddr_q <= {awaddr[7:2], 2'h0};
      end
      if (wvalid && wready) begin
        wGot_q  <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite) begin
        awGot_q <= 1'b0;
        wGot_q  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wrMapped ? `PK_AXI_OKAY : `PK_AXI_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // only the low byte lane carries control bits, the span honours every lane
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      velFormat_q <= 2'h0;
      scaleEver_q <= 1'b0;
      span_q      <= `PK_SPAN_RESET;
      irqEn_q     <= 3'h0;
    end else if (doWrite) begin
      if (awAddr_q == `PK_REG_CTRL && wStrb_q[0]) begin
        velFormat_q <= wData_q[`PK_CTRL_FMT_LSB +: 2];
        // sticky: clearing the bit later does not undo scaling
        scaleEver_q <= scaleEver_q | wData_q[`PK_CTRL_SCALE_BIT];
      end
      if (awAddr_q == `PK_REG_IRQ_EN && wStrb_q[0]) begin
        irqEn_q <= wData_q[2:0];
      end
      if (awAddr_q == `PK_REG_SPAN) begin
        for (int b = 0; b < 4; b++) begin
          if (wStrb_q[b]) begin
            span_q[8*b +: 8] <= wData_q[8*b +: 8];
          end
        end
      end
    end
  end

  a_scale_sticky: assert property (scaleEver_q |=> scaleEver_q)
    else $error("scaling selection was lost");

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `PK_AXI_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= `PK_AXI_OKAY;
        case ({araddr[7:2], 2'h0})
          `PK_REG_CTRL:     rdata <= {29'h00000000, scaleEver_q, velFormat_q};
          `PK_REG_SPAN:     rdata <= span_q;
          `PK_REG_STATUS:   rdata <= {layout_q, 6'h00, connActive, timeSyncFlag, 1'b0, updCount_q};
          `PK_REG_IRQ_STAT: rdata <= {29'h00000000, irqStat_q};
          `PK_REG_IRQ_EN:   rdata <= {29'h00000000, irqEn_q};
          `PK_REG_IRQ_CLR:  rdata <= 32'h00000000;
          default: begin
            rdata <= 32'h00000000;
            rresp <= `PK_AXI_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule : encoder_input_assembly_packer

/* File: tb/controller_model.sv */
// controller side of the cyclic link: opens and closes connections, takes packet words
// assumes the bench calls request and close right after a rising clock edge
`timescale 1ns/1ps
module controller_model (
  input  wire logic        clk,
  output logic             connReqValid,
  output logic [7:0]       connReqLayout,
  output logic [7:0]       connReqCfgLayout,
  output logic [15:0]      connReqRpiMs,
  output logic             connClose,
  input  wire logic        pktValid,
  input  wire logic [31:0] pktData,
  input  wire logic [2:0]  pktIndex,
  input  wire logic        pktLast,
  output logic             pktReady
);
  // ****************************************
  // requests and sink
  // ****************************************
  logic [35:0] rxQ[$];
  logic        slow;
  logic [1:0]  stall;
  initial begin
    {connReqValid, connClose, slow, stall, pktReady} = '0;
    {connReqLayout, connReqCfgLayout, connReqRpiMs} = '0;
  end
  // slow mode takes one word in four cycles, so words must stand until taken
  always @(posedge clk) begin
    stall <= stall + 2'h1;
    pktReady <= !slow || (stall == 2'h3);
    if (pktValid && pktReady) rxQ.push_back({pktLast, pktIndex, pktData});
  end
  // callers pass interval 2 ms; cfg 103 and the layout they size for, except in the refusal checks
  task automatic request(input logic [7:0] lay, input logic [7:0] cfg, input logic [15:0] rpi);
    connReqLayout <= lay;
    connReqCfgLayout <= cfg;
    connReqRpiMs <= rpi;
    connReqValid <= 1'b1;
    @(posedge clk);
    connReqValid <= 1'b0;
    connReqLayout <= ~lay;
  endtask : request
  task automatic close();
    connClose <= 1'b1;
    @(posedge clk);
    connClose <= 1'b0;
  endtask : close
endmodule : controller_model

/* File: tb/tb_top.sv */
// self-checking bench of the cyclic input packer
// assumes the controller model on the packet side; the bench is the AXI4-Lite master
`timescale 1ns/1ps
`include "packer_consts.svh"
module tb_top;
  import packer_pkg::*;
  // ****************************************
  // signals and helpers
  // ****************************************
  localparam int MS = 40;
  logic        clk, rst_b, syncLockPin, awvalid, wvalid, bready, arvalid, rready;
  logic        connReqValid, connClose, connRespValid, connActive, pktValid, pktLast;
  logic        pktReady, irq, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  connReqLayout, connReqCfgLayout, awaddr, araddr, lay;
  logic [15:0] connReqRpiMs, connRespCode;
  logic [31:0] posIn, wdata, pktData, rdata, d;
  logic [63:0] timerIn;
  logic [2:0]  pktIndex;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  wstrb;
  logic [35:0] x;
  logic [14:0] c0;
  int          n_fail, total_checks, seed, cyc, n, k, i, j, nw;
  always #5 clk = ~clk;
  encoder_input_assembly_packer #(.MS_CYCLES(MS)) encoder_input_assembly_packer_i (
    .clk, .rst_b, .posIn, .timerIn, .syncLockPin, .connReqValid, .connReqLayout,
    .connReqCfgLayout, .connReqRpiMs, .connClose, .connRespValid, .connRespCode, .connActive,
    .pktValid, .pktData, .pktIndex, .pktLast, .pktReady, .irq, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);
  controller_model controller_model_i (.clk, .connReqValid, .connReqLayout, .connReqCfgLayout,
    .connReqRpiMs, .connClose, .pktValid, .pktData, .pktIndex, .pktLast, .pktReady);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // bready and rready stay high, so each answer is taken on its first edge
  task automatic axiWr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid} <= 2'h3;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask : axiWr
  task automatic axiRd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : axiRd
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {clk, rst_b, posIn, timerIn, syncLockPin, awaddr, araddr, wdata, awvalid, wvalid} = '0;
    {arvalid, bready, rready, wstrb} = 7'h3F;
    {n_fail, total_checks, cyc} = '0;
    seed = 83;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    axiRd(`PK_REG_SPAN);
    chk("span reset", d, `PK_SPAN_RESET);
    axiRd(8'h3C);
    chk("hole resp", 32'(r), 32'(`PK_AXI_SLVERR));
    axiWr(`PK_REG_STATUS, 32'hFFFFFFFF);
    chk("status write", 32'(r), 32'(`PK_AXI_SLVERR));
    axiWr(`PK_REG_CTRL, 32'h00000005);
    axiRd(`PK_REG_CTRL);
    chk("ctrl set", d, 32'h00000005);
    axiWr(`PK_REG_CTRL, 32'h00000002);
    axiRd(`PK_REG_CTRL);
    chk("scale sticky", d, 32'h00000006);
    axiWr(`PK_REG_IRQ_EN, 32'h2);
    for (k = 0; k < 2; k++) begin
      controller_model_i.request(k ? `PK_LAYOUT_POS : 8'h02, k ? 8'h68 : `PK_LAYOUT_CFG, 16'h2);
      #1;
      chk("refuse code", 32'(connRespCode), 32'(`PK_ERR_SEGMENT));
      chk("refuse active", 32'(connActive), 32'h0);
      chk("resp strobe", 32'(connRespValid), 32'h1);
      @(posedge clk);
    end
    chk("reject irq", 32'(irq), 32'h1);
    axiWr(`PK_REG_IRQ_CLR, 32'h2);
    repeat (2) @(posedge clk);
    chk("cleared irq", 32'(irq), 32'h0);
    axiWr(`PK_REG_IRQ_EN, 32'h1);
    repeat (MS + 2) @(posedge clk);
    chk("refresh irq", 32'(irq), 32'h1);
    axiWr(`PK_REG_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    chk("masked irq", 32'(irq), 32'h0);
    for (k = 0; k < 3; k++) begin
      lay = (k == 0) ? `PK_LAYOUT_POS : (k == 1) ? `PK_LAYOUT_VEL : `PK_LAYOUT_SYNC;
      nw = (k == 0) ? 1 : (k == 1) ? 2 : 5;
      posIn <= (k == 0) ? 32'h70000000 : ($random(seed) & 32'h3FFFFFFF);
      timerIn <= {$random(seed), $random(seed)};
      syncLockPin <= 1'($random(seed));
      controller_model_i.slow = (k == 1);
      repeat (MS + 9) @(posedge clk);
      controller_model_i.rxQ.delete();
      controller_model_i.request(lay, `PK_LAYOUT_CFG, 16'h2);
      #1;
      chk("accept code", 32'(connRespCode), 32'h0);
      chk("accept active", 32'(connActive), 32'h1);
      axiRd(`PK_REG_STATUS);
      chk("status", d & 32'hFF030000, {lay, 6'h00, 1'b1, syncLockPin, 16'h0000});
      n = 0;
      while (controller_model_i.rxQ.size() < 2 * nw && n < 8 * MS) begin
        @(posedge clk);
        n++;
      end
      for (i = 0; i < 2 * nw; i++) begin
        x = (i < controller_model_i.rxQ.size()) ? controller_model_i.rxQ[i] : 36'h0;
        j = i % nw;
        chk("index", 32'(x[34:32]), 32'(j));
        chk("last", 32'(x[35]), 32'(j == nw - 1));
        case (j)
          0: chk("position", x[31:0], (posIn > `PK_POS_MAX) ? `PK_POS_MAX : posIn);
          1: if (i >= nw) chk("velocity", x[31:0], 32'h0);
          2: chk("time low", x[31:0], timerIn[31:0]);
          3: chk("time high", x[31:0], timerIn[63:32]);
          default: begin
            chk("flag word", x[31:0] & 32'hFFFF8000, {15'h0, syncLockPin, 16'h0});
            if (i == 4) c0 = x[14:0];
          end
        endcase
      end
      if (nw == 5) chk("counter step", 32'(15'(x[14:0] - c0)), 32'h2);
      controller_model_i.close();
      #1;
      chk("closed", 32'(connActive), 32'h0);
      @(posedge clk);
    end
    axiRd(`PK_REG_IRQ_STAT);
    chk("irq status", d, 32'h00000005);
    summarize();
  end
endmodule : tb_top
